// file: hw/tap_consts.svh
// Constants of the boundary-scan test access port.
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH
`define IR_LEN 3
`define IDR_LEN 32
`define BSR_LEN 54
`define IR_CAPTURE_BITS 2'b01
`define IR_RESET_CODE 3'h1
`define OP_EXTEST 3'h0
`define OP_IDCODE 3'h1
`define OP_SAMPLE_Z 3'h2
`define OP_SAMPLE 3'h4
`define OP_BYPASS 3'h7
`define IDR_DEPTH 5'h07
`define IDR_WIDTH 5'h03
`define IDR_RESERVED 6'h00
`define IDR_PRESENT 1'h1
`endif

// file: hw/tap_pkg.sv
// Types of the boundary-scan test access port.
package tap_pkg;
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PAU_DR = 16'h0040, ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PAU_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
    } tap_state_t;

    typedef struct packed {
        logic tdi;
        logic tms;
    } link_in_t;

    // State of the link-clock domain.
    typedef struct packed {
        tap_state_t st;
        logic [2:0] ir_sh;
        logic [2:0] ir;
        logic byp;
        logic [31:0] idr;
        logic [53:0] bsr;
        logic [53:0] ring_s1;
        logic [53:0] ring_s2;
        logic tdo;
        logic tdo_oe;
        logic hiz;
    } tap_regs_t;

    // State of the system-clock domain.
    typedef struct packed {
        logic hiz_s1;
        logic hiz_s2;
        logic outputs_off;
    } sys_regs_t;
endpackage : tap_pkg

// file: hw/boundary_scan_tap.sv
// Boundary-scan test access port with instruction, bypass, identification and scan chain.
`timescale 1ns/1ps
`include "tap_consts.svh"

module boundary_scan_tap
    import tap_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h0,
    // Maker code value is arbitrary.
    parameter logic [10:0] MAKER_CODE = 11'h2a5
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic tck,
    input wire logic tap_rst,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [53:0] pin_ring,
    output logic tdo,
    output logic tdo_oe,
    output logic outputs_off
);
    tap_regs_t r;
    tap_regs_t next_r;
    sys_regs_t s;
    sys_regs_t next_s;
    link_in_t lin;
    logic tdo_fall;
    logic oe_fall;

    assign lin.tdi = tdi;
    assign lin.tms = tms;

    function automatic tap_state_t tap_next(input tap_state_t cur, input logic m);
        case (cur)
            ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
            ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
            default: tap_next = ST_RESET;
        endcase
    endfunction : tap_next

    function automatic logic uses_chain(input logic [2:0] op);
        uses_chain = (op == `OP_EXTEST) || (op == `OP_SAMPLE_Z) || (op == `OP_SAMPLE);
    endfunction : uses_chain

    function automatic logic [31:0] id_word(input logic [3:0] rev, input logic [10:0] mk);
        id_word = {rev, `IDR_DEPTH, `IDR_WIDTH, `IDR_RESERVED, mk, `IDR_PRESENT};
    endfunction : id_word

    // Link-domain next state; the serial bit is chosen here and driven on the falling edge.
    always_comb begin
        next_r = r;
        next_r.st = tap_next(r.st, lin.tms);
        // The pin ring is asynchronous to the test clock, so every bit passes two flip-flops.
        // Pins must still stand still around a capture for the snapshot to be repeatable.
        next_r.ring_s1 = pin_ring;
        next_r.ring_s2 = r.ring_s1;
        case (r.st)
            ST_RESET: begin
                next_r.ir = `IR_RESET_CODE;
            end
            ST_CAP_IR: begin
                next_r.ir_sh = {r.ir[2], `IR_CAPTURE_BITS};
            end
            ST_SH_IR: begin
                next_r.ir_sh = {lin.tdi, r.ir_sh[2:1]};
            end
            ST_UPD_IR: begin
                next_r.ir = r.ir_sh;
            end
            ST_CAP_DR: begin
                if (r.ir == `OP_IDCODE) begin
                    next_r.idr = id_word(REVISION, MAKER_CODE);
                end else if (uses_chain(r.ir)) begin
                    next_r.bsr = r.ring_s2;
                end else begin
                    next_r.byp = 1'b0;
                end
            end
            ST_SH_DR: begin
                if (r.ir == `OP_IDCODE) begin
                    next_r.idr = {lin.tdi, r.idr[31:1]};
                end else if (uses_chain(r.ir)) begin
                    next_r.bsr = {lin.tdi, r.bsr[53:1]};
                end else begin
                    next_r.byp = lin.tdi;
                end
            end
            default: begin
            end
        endcase
        next_r.tdo_oe = (next_r.st == ST_SH_DR) || (next_r.st == ST_SH_IR);
        if (next_r.st == ST_SH_IR) begin
            next_r.tdo = next_r.ir_sh[0];
        end else if (next_r.ir == `OP_IDCODE) begin
            next_r.tdo = next_r.idr[0];
        end else if (uses_chain(next_r.ir)) begin
            next_r.tdo = next_r.bsr[0];
        end else begin
            next_r.tdo = next_r.byp;
        end
        // Update-DR under code 100 has no preload, so the chain never reaches the pins.
        next_r.hiz = (next_r.ir == `OP_EXTEST) || (next_r.ir == `OP_SAMPLE_Z);
    end

    always_ff @(posedge tck) begin
        if (tap_rst) begin
            r <= '{st: ST_RESET, ir_sh: 3'h0, ir: `IR_RESET_CODE, byp: 1'b0, idr: 32'h0,
                   bsr: 54'h0, ring_s1: 54'h0, ring_s2: 54'h0,
                   tdo: 1'b0, tdo_oe: 1'b0, hiz: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    always_ff @(negedge tck) begin
        if (tap_rst) begin
            tdo_fall <= 1'b0;
            oe_fall <= 1'b0;
        end else begin
            tdo_fall <= r.tdo;
            oe_fall <= r.tdo_oe;
        end
    end

    assign tdo = tdo_fall;
    assign tdo_oe = oe_fall;

    // The float request crosses to the system clock through three flip-flops.
    always_comb begin
        next_s.hiz_s1 = r.hiz;
        next_s.hiz_s2 = s.hiz_s1;
        next_s.outputs_off = s.hiz_s2;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign outputs_off = s.outputs_off;

    property p_ir_capture;
        @(posedge tck) disable iff (tap_rst)
        r.st == ST_CAP_IR |=> r.ir_sh[1:0] == `IR_CAPTURE_BITS;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("capture-IR bits wrong");

    property p_ir_hold;
        @(posedge tck) disable iff (tap_rst)
        (r.st != ST_UPD_IR && r.st != ST_RESET) |=> $stable(r.ir);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("instruction changed early");

    property p_ir_update;
        @(posedge tck) disable iff (tap_rst)
        r.st == ST_UPD_IR |=> r.ir == $past(r.ir_sh);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("update-IR lost code");

    property p_reset_id;
        @(posedge tck) disable iff (tap_rst)
        r.st == ST_RESET |=> r.ir == `OP_IDCODE;
    endproperty
    a_reset_id: assert property (p_reset_id) else $error("reset code not identify");

    property p_id_cap;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_CAP_DR && r.ir == `OP_IDCODE) |=> r.idr[0] == 1'b1 && r.idr[27:18] == 10'h0e3;
    endproperty
    a_id_cap: assert property (p_id_cap) else $error("identification word wrong");

    property p_byp_zero;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_CAP_DR && r.ir == `OP_BYPASS) |=> r.byp == 1'b0;
    endproperty
    a_byp_zero: assert property (p_byp_zero) else $error("bypass not zero");

    property p_chain_cap;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_CAP_DR && r.ir == `OP_SAMPLE) |=> r.bsr == $past(r.ring_s2) && !r.hiz;
    endproperty
    a_chain_cap: assert property (p_chain_cap) else $error("sample capture wrong");

    property p_float;
        @(posedge tck) disable iff (tap_rst)
        (r.ir == `OP_SAMPLE_Z || r.ir == `OP_EXTEST) |-> r.hiz;
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated");

    property p_tms_reset;
        @(posedge tck) disable iff (tap_rst)
        lin.tms [*5] |=> r.st == ST_RESET;
    endproperty
    a_tms_reset: assert property (p_tms_reset) else $error("five ones miss reset");

    property p_tdo_fall;
        @(negedge tck) disable iff (tap_rst)
        1'b1 |=> tdo == $past(r.tdo);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("serial output timing");

    property p_off_sync;
        @(posedge mclk) disable iff (srst)
        s.hiz_s2 |=> outputs_off;
    endproperty
    a_off_sync: assert property (p_off_sync) else $error("float not passed");

    property p_off_clear;
        @(posedge mclk) disable iff (srst)
        !s.hiz_s2 |=> !outputs_off;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("float not released");

    property p_srst_off;
        @(posedge mclk)
        srst |=> !outputs_off;
    endproperty
    a_srst_off: assert property (p_srst_off) else $error("float set in reset");

    property p_tap_rst;
        @(posedge tck)
        tap_rst |=> r.st == ST_RESET && r.ir == `OP_IDCODE;
    endproperty
    a_tap_rst: assert property (p_tap_rst) else $error("power-up reset wrong");

    property p_no_float;
        @(posedge tck) disable iff (tap_rst)
        (r.ir == `OP_IDCODE || r.ir == `OP_SAMPLE || r.ir == `OP_BYPASS) |-> !r.hiz;
    endproperty
    a_no_float: assert property (p_no_float) else $error("outputs floated");

    property p_upd_dr_hold;
        @(posedge tck) disable iff (tap_rst)
        r.st == ST_UPD_DR |=> $stable(r.hiz) && $stable(r.bsr);
    endproperty
    a_upd_dr_hold: assert property (p_upd_dr_hold) else $error("update-DR acted");

    property p_ir_shift;
        @(posedge tck) disable iff (tap_rst)
        r.st == ST_SH_IR |=> r.ir_sh == (($past(r.ir_sh) >> 1) | {$past(lin.tdi), 2'h0});
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong");

    property p_id_shift;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_SH_DR && r.ir == `OP_IDCODE) |=>
            r.idr == (($past(r.idr) >> 1) | {$past(lin.tdi), 31'h0});
    endproperty
    a_id_shift: assert property (p_id_shift) else $error("identification shift wrong");

    property p_chain_shift;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_SH_DR && uses_chain(r.ir)) |=>
            r.bsr == (($past(r.bsr) >> 1) | {$past(lin.tdi), 53'h0});
    endproperty
    a_chain_shift: assert property (p_chain_shift) else $error("chain shift wrong");

    property p_byp_path;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_SH_DR && r.ir == `OP_BYPASS) |=> r.byp == $past(lin.tdi);
    endproperty
    a_byp_path: assert property (p_byp_path) else $error("bypass path wrong");

    property p_ir_first;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_CAP_IR && !lin.tms) |=> r.tdo;
    endproperty
    a_ir_first: assert property (p_ir_first) else $error("first instruction bit wrong");

    property p_id_first;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_CAP_DR && r.ir == `OP_IDCODE && !lin.tms) |=> r.tdo;
    endproperty
    a_id_first: assert property (p_id_first) else $error("presence bit not first");

    property p_byp_first;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_CAP_DR && r.ir == `OP_BYPASS && !lin.tms) |=> !r.tdo;
    endproperty
    a_byp_first: assert property (p_byp_first) else $error("bypass first bit wrong");

    property p_chain_first;
        @(posedge tck) disable iff (tap_rst)
        (r.st == ST_CAP_DR && uses_chain(r.ir) && !lin.tms) |=>
            {53'h0, r.tdo} == ($past(r.ring_s2) & 54'h1);
    endproperty
    a_chain_first: assert property (p_chain_first) else $error("first cell wrong");

    property p_oe_shift;
        @(negedge tck) disable iff (tap_rst)
        (r.st == ST_SH_DR || r.st == ST_SH_IR) |=> tdo_oe;
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("output enable low in shift");

    property p_oe_idle;
        @(negedge tck) disable iff (tap_rst)
        r.st == ST_IDLE |=> !tdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output enable high in idle");

    c_id_shift: cover property (@(posedge tck) r.st == ST_SH_DR && r.ir == `OP_IDCODE);
    c_bypass: cover property (@(posedge tck) r.st == ST_SH_DR && r.ir == `OP_BYPASS);
    c_ir_load: cover property (@(posedge tck) r.st == ST_UPD_IR && r.ir_sh == `OP_SAMPLE_Z);
    c_off: cover property (@(posedge mclk) outputs_off);
endmodule : boundary_scan_tap

// file: testbench/scan_master.sv
// Behavioural test controller that clocks the scan port and shifts words through it.
`timescale 1ns/1ps
module scan_master (
    output logic tck,
    output logic tap_rst,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tap_rst = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // The test clock stands still between calls; inputs change in the low phase.
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3;
        q = tdo;
        tck = 1'b1;
        #3;
        tck = 1'b0;
    endtask : pulse

    // Outside a shift the serial input keeps toggling so no stale bit looks valid.
    task automatic walk(input logic m);
        logic q;
        pulse(m, ~tdi, q);
    endtask : walk

    // The reset line moves clear of the falling edge so the output flops see one value.
    task automatic reset(input logic pin);
        #1;
        tap_rst = pin;
        repeat (5) walk(1'b1);
        #1;
        tap_rst = 1'b0;
        walk(1'b0);
    endtask : reset

    // Shifts n bits from idle through one register and returns to idle.
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        dout = '0;
        walk(1'b1);
        if (ir) begin
            walk(1'b1);
        end
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(1'b1);
        walk(1'b0);
    endtask : scan
endmodule : scan_master

// file: testbench/boundary_scan_tap_test.sv
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ps
module boundary_scan_tap_test;
    import tap_pkg::*;
    localparam logic [3:0] REV = 4'h3;
    // Maker code value is arbitrary.
    localparam logic [10:0] MAKER = 11'h155;
    localparam logic [31:0] IDENT = {REV, 5'b00111, 5'b00011, 6'h00, MAKER, 1'b1};
    localparam logic [53:0] RING = 54'h2d_1e0f_96c3_a55a;
    localparam logic [63:0] PAT = 64'hc0de_1234_5678_9abc;
    typedef struct packed {
        logic [2:0] code;
        logic [6:0] len;
        logic [63:0] cap;
        logic off;
    } row_t;
    // Only the defined codes are loaded.
    row_t rows [5] = '{
        '{3'h0, 7'h36, {10'h000, RING}, 1'b1},
        '{3'h2, 7'h36, {10'h000, RING}, 1'b1},
        '{3'h4, 7'h36, {10'h000, RING}, 1'b0},
        '{3'h1, 7'h20, {32'h0, IDENT}, 1'b0},
        '{3'h7, 7'h01, 64'h0, 1'b0}
    };
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic tck;
    logic tap_rst;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic outputs_off;
    logic [53:0] pin_ring = RING;
    logic [2:0] prev;
    logic [63:0] got;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    always #20 mclk = ~mclk;

    boundary_scan_tap #(.REVISION(REV), .MAKER_CODE(MAKER)) boundary_scan_tap_i (
        .mclk(mclk), .srst(srst), .tck(tck), .tap_rst(tap_rst), .tms(tms), .tdi(tdi),
        .pin_ring(pin_ring), .tdo(tdo), .tdo_oe(tdo_oe), .outputs_off(outputs_off));
    scan_master scan_master_i (.tck(tck), .tap_rst(tap_rst), .tms(tms), .tdi(tdi), .tdo(tdo));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic settle();
        repeat (6) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        scan_master_i.reset(1'b1);
        prev = 3'h1;
        foreach (rows[k]) begin
            scan_master_i.scan(1'b1, 3, {61'h0, rows[k].code}, got);
            check("ir capture", got, {61'h0, prev[2], 2'b01});
            prev = rows[k].code;
            settle();
            check("outputs off", outputs_off, rows[k].off);
            scan_master_i.scan(1'b0, 64, PAT, got);
            check("data scan", got, (PAT << rows[k].len) | rows[k].cap);
            check("tdo enable idle", tdo_oe, 1'b0);
            $display("row %0d code %h done", k, rows[k].code);
        end
        scan_master_i.scan(1'b1, 3, 64'h0, got);
        check("ir capture", got, 64'h5);
        settle();
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        check("outputs off in reset", outputs_off, 1'b0);
        settle();
        check("outputs off after reset", outputs_off, 1'b1);
        $display("system reset test done");
        scan_master_i.reset(1'b0);
        settle();
        check("outputs off after tap reset", outputs_off, 1'b0);
        scan_master_i.scan(1'b0, 64, PAT, got);
        check("ident after tap reset", got, (PAT << 32) | {32'h0, IDENT});
        $display("tap reset test done");
        end_of_test();
    end
endmodule : boundary_scan_tap_test
